/* File: design/sampling_pkg.sv */
package sampling_pkg;
   // ****************************************
   // Counter layout
   // ****************************************
   localparam int NUM_CTR = 8;
   localparam int NUM_SAMPLE_CTR = 4;
   localparam int STORE_CTR = 3;
   localparam int PDIST_CTR = 1;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REC_W = 64;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] REG_ENABLE_LO = 8'h00;
   localparam logic [7:0] REG_ENABLE_HI = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ARMED = 8'h0C;
   localparam logic [7:0] REG_SEL_BASE = 8'h20;
   localparam logic [7:0] REG_SEL_LAST = 8'h3C;

   // ****************************************
   // Sampling enable register fields
   // ****************************************
   localparam int EN_LAT_LSB = 32;
   localparam int EN_STORE_BIT = 63;
   localparam logic [63:0] ENABLE_RESET = 64'h0000_0000_0000_0000;
   localparam logic [31:0] SEL_RESET = 32'h0000_0000;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // ****************************************
   // Event selector fields
   // ****************************************
   localparam int SEL_EVT_LSB = 0;
   localparam int SEL_MASK_LSB = 8;
   localparam int SEL_EDGE_BIT = 18;
   localparam int SEL_ANY_BIT = 21;
   localparam int SEL_INV_BIT = 23;
   localparam int SEL_COUNTER_MASK_FIELD_LSB = 24;

   // ****************************************
   // Record field offsets
   // ****************************************
   localparam logic [7:0] REC_OFS_ADDR = 8'h98;
   localparam logic [7:0] REC_OFS_SOURCE = 8'hA0;
   localparam logic [7:0] REC_OFS_LATENCY = 8'hA8;
   localparam int SRC_STLB_BIT = 4;
   localparam int SRC_LOCK_BIT = 5;
   localparam int ST_L1_BIT = 0;

   // ****************************************
   // Eligible event selects
   // ****************************************
   localparam logic [7:0] EVT_INSTRUCTIONS_RETIRED_EVENT = 8'hC0;
   localparam logic [7:0] EVT_UOP_RETIRED = 8'hC2;
   localparam logic [7:0] EVT_BRANCH = 8'hC4;
   localparam logic [7:0] EVT_MISP_BRANCH = 8'hC5;
   localparam logic [7:0] EVT_MEM_TRANS = 8'hCD;
   localparam logic [7:0] EVT_MEM_UOP = 8'hD0;
   localparam logic [7:0] EVT_LOAD = 8'hD1;
   localparam logic [7:0] EVT_LLC_HIT_LOAD = 8'hD2;
   localparam logic [7:0] EVT_MISC_LOAD = 8'hD4;

   // ****************************************
   // Sub-event masks
   // ****************************************
   localparam logic [7:0] MASK_PRECISE_DISTRIBUTION_SUBEVENT = 8'h01;
   localparam logic [7:0] MASK_LOAD_LAT = 8'h01;
   localparam logic [7:0] MASK_STORE_CAP = 8'h02;
   localparam logic [7:0] MASK_LLC_MISS = 8'h02;
   localparam logic [7:0] MASKS_UOP = 8'h03;
   localparam logic [7:0] MASKS_BRANCH = 8'h7F;
   localparam logic [7:0] MASKS_MISP = 8'h37;
   localparam logic [7:0] MASKS_MEM_UOP = 8'hF3;
   localparam logic [7:0] MASKS_LOAD = 8'h47;
   localparam logic [7:0] MASKS_LLC_HIT = 8'h0F;

   typedef enum logic [1:0] {PH_IDLE, PH_CLEAR} phase_e;
endpackage

/* File: design/precise_sampling_record_logic.sv */
`timescale 1ns/1ps
// Function
// - Only counters zero to three sample; four to seven never arm or record.
// - Enable bit 63 lets counter three capture store information.
// - Store capture happens on counter three alone.
// - Field 98H holds load source or store destination linear address.
// - In load-latency mode field A0H holds source, translation miss and lock.
// - In store-capture mode field A0H holds store status bits.
// - In load-latency mode field A8H holds the load latency.
// - In store-capture mode field A8H is written zero.
// - After a record, clear overflow status of overflowed and enabled counters zero to three.
// - Overflow status of other counters stays unchanged.
// - Precise-distribution mask 01H of event C0H is eligible only on counter one.
// - Event C2H with masks 01H and 02H is eligible.
// - Event C4H with masks 01H to 40H listed is eligible.
// - Event C5H with masks 01H, 02H, 04H, 10H, 20H is eligible.
// - Event CDH mask 01H is load latency, mask 02H is store capture.
// - Event D0H with masks 01H, 02H, 10H, 20H, 40H, 80H is eligible.
// - Event D1H with masks 01H, 02H, 04H, 40H is eligible.
// - Event D2H with masks 01H, 02H, 04H, 08H is eligible.
// - Event D4H with mask 02H is eligible.
module precise_sampling_record_logic
   import sampling_pkg::*;
#(
   parameter int NUM_COUNTERS = NUM_CTR,
   parameter int LAT_W = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdata,
   input wire logic [NUM_COUNTERS-1:0] ctrOverflow,
   input wire logic [NUM_COUNTERS-1:0] sampleEvent,
   input wire logic [REC_W-1:0] loadAddr,
   input wire logic [3:0] loadSource,
   input wire logic loadStlbMiss,
   input wire logic loadLocked,
   input wire logic [LAT_W-1:0] loadLatency,
   input wire logic [REC_W-1:0] storeAddr,
   input wire logic storeL1Hit,
   input wire logic storeStlbMiss,
   input wire logic storeLocked,
   output logic recValid,
   output logic [2:0] recCounter,
   output logic [REC_W-1:0] recLinAddr,
   output logic [REC_W-1:0] recDataSrc,
   output logic [REC_W-1:0] recLatency,
   output logic [NUM_COUNTERS-1:0] overflowStatus,
   output logic [NUM_COUNTERS-1:0] armed
);

   // ****************************************
   // Eligibility table
   // ****************************************
   function automatic logic listedMask(input logic [7:0] evt, input logic [7:0] msk);
      listedMask = 1'b0;
      case (evt)
         EVT_UOP_RETIRED: begin
            case (msk)
               8'h01: listedMask = 1'b1;
               8'h02: listedMask = 1'b1;
               default: listedMask = 1'b0;
            endcase
         end
         EVT_BRANCH: begin
            case (msk)
               8'h01: listedMask = 1'b1;
               8'h02: listedMask = 1'b1;
               8'h04: listedMask = 1'b1;
               8'h08: listedMask = 1'b1;
               8'h10: listedMask = 1'b1;
               8'h20: listedMask = 1'b1;
               8'h40: listedMask = 1'b1;
               default: listedMask = 1'b0;
            endcase
         end
         EVT_MISP_BRANCH: begin
            case (msk)
               8'h01: listedMask = 1'b1;
               8'h02: listedMask = 1'b1;
               8'h04: listedMask = 1'b1;
               8'h10: listedMask = 1'b1;
               8'h20: listedMask = 1'b1;
               default: listedMask = 1'b0;
            endcase
         end
         EVT_MEM_UOP: begin
            case (msk)
               8'h01: listedMask = 1'b1;
               8'h02: listedMask = 1'b1;
               8'h10: listedMask = 1'b1;
               8'h20: listedMask = 1'b1;
               8'h40: listedMask = 1'b1;
               8'h80: listedMask = 1'b1;
               default: listedMask = 1'b0;
            endcase
         end
         EVT_LOAD: begin
            case (msk)
               8'h01: listedMask = 1'b1;
               8'h02: listedMask = 1'b1;
               8'h04: listedMask = 1'b1;
               8'h40: listedMask = 1'b1;
               default: listedMask = 1'b0;
            endcase
         end
         EVT_LLC_HIT_LOAD: begin
            case (msk)
               8'h01: listedMask = 1'b1;
               8'h02: listedMask = 1'b1;
               8'h04: listedMask = 1'b1;
               8'h08: listedMask = 1'b1;
               default: listedMask = 1'b0;
            endcase
         end
         default: listedMask = 1'b0;
      endcase
   endfunction

   function automatic logic eventOk(input logic [31:0] sel, input int idx);
      logic [7:0] evt;
      logic [7:0] msk;
      logic anyOff;
      logic edgeOff;
      logic invOff;
      logic cmaskOff;
      logic clean;
      evt = sel[SEL_EVT_LSB +: 8];
      msk = sel[SEL_MASK_LSB +: 8];
      anyOff = !sel[SEL_ANY_BIT];
      edgeOff = !sel[SEL_EDGE_BIT];
      invOff = !sel[SEL_INV_BIT];
      cmaskOff = (sel[SEL_COUNTER_MASK_FIELD_LSB +: 8] == 8'h00);
      clean = anyOff && edgeOff && invOff && cmaskOff;
      case (evt)
         EVT_INSTRUCTIONS_RETIRED_EVENT: eventOk = (msk == MASK_PRECISE_DISTRIBUTION_SUBEVENT) && (idx == PDIST_CTR);
         EVT_UOP_RETIRED: eventOk = listedMask(evt, msk);
         EVT_BRANCH: eventOk = listedMask(evt, msk);
         EVT_MISP_BRANCH: eventOk = listedMask(evt, msk);
         EVT_MEM_TRANS: eventOk = (msk == MASK_LOAD_LAT)
            || ((msk == MASK_STORE_CAP) && (idx == STORE_CTR));
         EVT_MEM_UOP: eventOk = listedMask(evt, msk);
         EVT_LOAD: eventOk = listedMask(evt, msk);
         EVT_LLC_HIT_LOAD: eventOk = listedMask(evt, msk);
         EVT_MISC_LOAD: eventOk = (msk == MASK_LLC_MISS);
         default: eventOk = 1'b0;
      endcase
      eventOk = eventOk && clean;
   endfunction

   // ****************************************
   // Record field formats
   // ****************************************
   function automatic logic [REC_W-1:0] loadSrcWord(input logic [3:0] src,
         input logic stlb, input logic lock);
      loadSrcWord = '0;
      loadSrcWord[3:0] = src;
      loadSrcWord[SRC_STLB_BIT] = stlb;
      loadSrcWord[SRC_LOCK_BIT] = lock;
   endfunction

   function automatic logic [REC_W-1:0] storeWord(input logic l1Hit, input logic stlb,
         input logic lock);
      storeWord = '0;
      storeWord[ST_L1_BIT] = l1Hit;
      storeWord[SRC_STLB_BIT] = stlb;
      storeWord[SRC_LOCK_BIT] = lock;
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   logic [63:0] sampleEnable;
   logic [31:0] evtSel [NUM_COUNTERS];
   phase_e phase;
   logic [NUM_COUNTERS-1:0] eligible;
   logic [NUM_COUNTERS-1:0] fire;
   logic [NUM_COUNTERS-1:0] clearMask;
   logic [NUM_COUNTERS-1:0] storeCtr;
   logic [NUM_COUNTERS-1:0] latCtr;
   logic [NUM_COUNTERS-1:0] swClear;
   logic [2:0] next_recCounter;
   logic storeMode;
   logic latMode;
   logic selHit;
   logic [2:0] selIdx;

   assign selHit = (regAddr >= REG_SEL_BASE) && (regAddr <= REG_SEL_LAST)
      && (regAddr[1:0] == 2'b00);
   assign selIdx = 3'((regAddr - REG_SEL_BASE) >> 2);

   // ****************************************
   // Enable register
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sampleEnable <= ENABLE_RESET;
      end else if (regWr && regAddr == REG_ENABLE_LO) begin
         sampleEnable[31:0] <= regWdata;
      end else if (regWr && regAddr == REG_ENABLE_HI) begin
         sampleEnable[63:32] <= regWdata;
      end
   end

   // ****************************************
   // Per-counter selectors and arming
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NUM_COUNTERS; g++) begin : gCtr
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               evtSel[g] <= SEL_RESET;
            end else if (regWr && selHit && selIdx == 3'(g)) begin
               evtSel[g] <= regWdata;
            end
         end

         if (g < NUM_SAMPLE_CTR) begin : gSample
            assign eligible[g] = sampleEnable[g] && eventOk(evtSel[g], g);
            if (g == STORE_CTR) begin : gStore
               assign storeCtr[g] = sampleEnable[EN_STORE_BIT]
                  && (evtSel[g][15:0] == {MASK_STORE_CAP, EVT_MEM_TRANS});
            end else begin : gNoStore
               assign storeCtr[g] = 1'b0;
            end
            assign latCtr[g] = sampleEnable[EN_LAT_LSB + g]
               && (evtSel[g][15:0] == {MASK_LOAD_LAT, EVT_MEM_TRANS});
         end else begin : gPlain
            assign eligible[g] = 1'b0;
            assign storeCtr[g] = 1'b0;
            assign latCtr[g] = 1'b0;
         end

         // Overflow arms, the following event fires
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               armed[g] <= 1'b0;
            end else if (!eligible[g]) begin
               armed[g] <= 1'b0;
            end else if (fire[g]) begin
               armed[g] <= 1'b0;
            end else if (ctrOverflow[g]) begin
               armed[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // ****************************************
   // Record generation
   // ****************************************
   always_comb begin
      fire = '0;
      next_recCounter = 3'd0;
      for (int i = NUM_COUNTERS - 1; i >= 0; i--) begin
         if (armed[i] && sampleEvent[i] && phase == PH_IDLE) begin
            fire = '0;
            fire[i] = 1'b1;
            next_recCounter = 3'(i);
         end
      end
   end

   // ****************************************
   // Sampling mode
   // ****************************************
   always_comb begin
      storeMode = |(fire & storeCtr);
      latMode = |(fire & latCtr);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         recValid <= 1'b0;
         recCounter <= 3'd0;
      end else begin
         recValid <= |fire;
         if (|fire) begin
            recCounter <= next_recCounter;
         end
      end
   end

   // ****************************************
   // Record fields
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         recLinAddr <= '0;
         recDataSrc <= '0;
         recLatency <= '0;
      end else if (|fire) begin
         recLinAddr <= '0;
         recDataSrc <= '0;
         recLatency <= '0;
         if (storeMode) begin
            recLinAddr <= storeAddr;
            recDataSrc <= storeWord(storeL1Hit, storeStlbMiss, storeLocked);
            recLatency <= '0;
         end else if (latMode) begin
            recLinAddr <= loadAddr;
            recDataSrc <= loadSrcWord(loadSource, loadStlbMiss, loadLocked);
            recLatency <= REC_W'(loadLatency);
         end
      end
   end

   // ****************************************
   // Overflow status and post-record clear
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= PH_IDLE;
      end else begin
         case (phase)
            PH_IDLE: phase <= (|fire) ? PH_CLEAR : PH_IDLE;
            PH_CLEAR: phase <= PH_IDLE;
            default: phase <= PH_IDLE;
         endcase
      end
   end

   always_comb begin
      clearMask = '0;
      if (phase == PH_CLEAR) begin
         clearMask = overflowStatus & NUM_COUNTERS'(sampleEnable[NUM_SAMPLE_CTR-1:0]);
      end
   end

   assign swClear = (regWr && regAddr == REG_STATUS) ? regWdata[NUM_COUNTERS-1:0] : '0;

   // Set wins over either clear
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         overflowStatus <= STATUS_RESET;
      end else begin
         overflowStatus <= (overflowStatus & ~(clearMask | swClear)) | ctrOverflow;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         regRdata <= '0;
      end else if (regRd) begin
         regRdata <= '0;
         if (regAddr == REG_ENABLE_LO) begin
            regRdata <= sampleEnable[31:0];
         end else if (regAddr == REG_ENABLE_HI) begin
            regRdata <= sampleEnable[63:32];
         end else if (regAddr == REG_STATUS) begin
            regRdata <= DATA_W'(overflowStatus);
         end else if (regAddr == REG_ARMED) begin
            regRdata <= DATA_W'(armed);
         end else if (selHit) begin
            regRdata <= evtSel[selIdx];
         end
      end else begin
         regRdata <= '0;
      end
   end

endmodule

/* File: testbench/sampling_assertions.sv */
`timescale 1ns/1ps
// ****
// Record checks
// ****
module sampling_assertions
   import sampling_pkg::*;
#(
   parameter int NUM_COUNTERS = NUM_CTR,
   parameter int LAT_W = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [NUM_COUNTERS-1:0] ctrOverflow,
   input wire logic [NUM_COUNTERS-1:0] sampleEvent,
   input wire logic recValid,
   input wire logic [2:0] recCounter,
   input wire logic [NUM_COUNTERS-1:0] overflowStatus,
   input wire logic [NUM_COUNTERS-1:0] armed
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence fire_s;
      ((armed & sampleEvent) != '0) && !recValid;
   endsequence
   property fire_p;
      fire_s |=> recValid;
   endproperty
   high_idle_a: assert property ((armed >> NUM_SAMPLE_CTR) == '0)
      else $error("high counter armed");
   rec_range_a: assert property (recValid |-> recCounter < 3'(NUM_SAMPLE_CTR))
      else $error("record from high counter");
   rec_fire_a: assert property (fire_p)
      else $error("fire without record");
   rec_cause_a: assert property (recValid |-> ($past(armed) & $past(sampleEvent)) != '0)
      else $error("record without armed event");
   rec_pulse_a: assert property (recValid |=> !recValid)
      else $error("record strobe too long");
   arm_cause_a: assert property ((armed & ~$past(armed) & ~$past(ctrOverflow)) == '0)
      else $error("armed without overflow");
   status_set_a: assert property ((ctrOverflow != '0) |=>
      (overflowStatus & $past(ctrOverflow)) == $past(ctrOverflow))
      else $error("overflow not recorded");
   status_clear_a: assert property (recValid && !ctrOverflow[recCounter] |=>
      !overflowStatus[$past(recCounter)])
      else $error("status not cleared");
   status_keep_a: assert property (recValid |=>
      ((~overflowStatus & $past(overflowStatus)) >> NUM_SAMPLE_CTR) == '0)
      else $error("other status cleared");
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
// ****
// Bench
// ****
module tb_top
   import sampling_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0000_0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic [7:0] ctrOverflow = 8'h00;
   logic [7:0] sampleEvent = 8'h00;
   logic [63:0] loadAddr = 64'h1234_5678_9ABC_DEF0;
   logic [63:0] storeAddr = 64'h0FED_CBA9_8765_4321;
   logic [15:0] loadLatency = 16'h0123;
   logic [3:0] loadSource = 4'hA;
   logic loadStlbMiss = 1'b1;
   logic loadLocked = 1'b0;
   logic storeL1Hit = 1'b1;
   logic storeStlbMiss = 1'b0;
   logic storeLocked = 1'b1;
   logic recValid;
   logic [2:0] recCounter;
   logic [63:0] recLinAddr, recDataSrc, recLatency;
   logic [7:0] overflowStatus, armed;
   int n_mismatch = 0;
   int comparisons = 0;
   precise_sampling_record_logic precise_sampling_record_logic_inst (
      .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ctrOverflow(ctrOverflow),
      .sampleEvent(sampleEvent), .loadAddr(loadAddr), .loadSource(loadSource),
      .loadStlbMiss(loadStlbMiss), .loadLocked(loadLocked), .loadLatency(loadLatency),
      .storeAddr(storeAddr), .storeL1Hit(storeL1Hit), .storeStlbMiss(storeStlbMiss),
      .storeLocked(storeLocked), .recValid(recValid), .recCounter(recCounter),
      .recLinAddr(recLinAddr), .recDataSrc(recDataSrc), .recLatency(recLatency),
      .overflowStatus(overflowStatus), .armed(armed));
   always #50 mclk = ~mclk;
   task automatic stop_test();
      $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      chk(regRdata === exp, what);
   endtask
   task automatic arm(input int c, input logic [31:0] sel, input logic [7:0] en, input logic exp);
      wr(REG_SEL_BASE + 8'(4 * c), sel);
      wr(REG_ENABLE_LO, {24'h00_0000, en});
      @(posedge mclk);
      ctrOverflow <= 8'h01 << c;
      @(posedge mclk);
      ctrOverflow <= 8'h00;
      @(negedge mclk);
      chk(armed[c] === exp, "armed flag");
      rd(REG_ARMED, 32'(exp) << c, "armed read");
      wr(REG_ENABLE_LO, 32'h0000_0000);
   endtask
   task automatic reg_check();
      rd(REG_ENABLE_LO, 32'h0000_0000, "enable reset");
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, 32'h0000_0000, "unmapped read");
      wr(REG_ENABLE_HI, 32'h8000_0001);
      rd(REG_ENABLE_HI, 32'h8000_0001, "enable high");
      wr(REG_ENABLE_HI, 32'h0000_0000);
   endtask
   task automatic elig_special();
      arm(1, 32'h0000_01C0, 8'h0F, 1'b1);
      arm(0, 32'h0000_01C0, 8'h0F, 1'b0);
      arm(2, 32'h0004_04C4, 8'h0F, 1'b0);
      arm(2, 32'h0020_04C4, 8'h0F, 1'b0);
      arm(2, 32'h0080_04C4, 8'h0F, 1'b0);
      arm(2, 32'h0100_04C4, 8'h0F, 1'b0);
      arm(2, 32'h0000_04C4, 8'h0B, 1'b0);
      arm(4, 32'h0000_04C4, 8'hFF, 1'b0);
      arm(2, 32'h0000_02CD, 8'h0F, 1'b0);
   endtask
   task automatic elig_table();
      logic [7:0] evts [7] = '{8'hC2, 8'hC4, 8'hC5, 8'hD0, 8'hD1, 8'hD2, 8'hD4};
      logic [7:0] oks [7] = '{8'h03, 8'h7F, 8'h37, 8'hF3, 8'h47, 8'h0F, 8'h02};
      logic [31:0] sel;
      for (int e = 0; e < 7; e++) begin
         for (int b = 0; b < 8; b++) begin
            sel = {16'h0000, 8'h01 << b, evts[e]};
            if (e < 4) begin
               arm(b % 4, sel, 8'h0F, oks[e][b]);
            end else begin
               arm(b % 4, sel, 8'h0F, oks[e][b]);
            end
         end
      end
   endtask
   task automatic record(input int c, input logic [7:0] m, input logic [31:0] hi,
         input logic [63:0] a, input logic [63:0] src, input logic [63:0] lat);
      wr(REG_STATUS, 32'h0000_00FF);
      wr(REG_SEL_BASE + 8'(4 * c), {16'h0000, m, 8'hCD});
      wr(REG_ENABLE_HI, hi);
      wr(REG_ENABLE_LO, 32'h0000_0001 << c);
      @(posedge mclk);
      ctrOverflow <= (8'h01 << c) | 8'h20;
      @(posedge mclk);
      ctrOverflow <= 8'h00;
      sampleEvent <= 8'h01 << c;
      @(posedge mclk);
      sampleEvent <= 8'h00;
      @(negedge mclk);
      chk(recValid === 1'b1 && recCounter === 3'(c), "record strobe");
      chk(recLinAddr === a, "linear address");
      chk(recDataSrc === src, "source field");
      chk(recLatency === lat, "latency field");
      @(negedge mclk);
      chk(overflowStatus === 8'h20, "status after record");
      wr(REG_ENABLE_LO, 32'h0000_0000);
      wr(REG_ENABLE_HI, 32'h0000_0000);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      reg_check();
      elig_special();
      elig_table();
      record(0, 8'h01, 32'h0000_0001, loadAddr, 64'h0000_0000_0000_001A,
         64'h0000_0000_0000_0123);
      record(3, 8'h02, 32'h8000_0000, storeAddr, 64'h0000_0000_0000_0021,
         64'h0000_0000_0000_0000);
      stop_test();
   end
   initial begin
      #500000;
      n_mismatch++;
      stop_test();
   end
endmodule
bind precise_sampling_record_logic sampling_assertions #(
   .NUM_COUNTERS(NUM_COUNTERS), .LAT_W(LAT_W)) sampling_assertions_inst (
   .mclk(mclk), .rst_b(rst_b), .ctrOverflow(ctrOverflow), .sampleEvent(sampleEvent),
   .recValid(recValid), .recCounter(recCounter), .overflowStatus(overflowStatus),
   .armed(armed));
